/* rtl/uart_aux_regs.vh */
// Purpose: constants for the UART auxiliary block
// Assumes: included by rtl/uart_aux.v only
// Notes: register offsets are word indexes; byte address is index * 4
`ifndef UART_AUX_REGS_VH
`define UART_AUX_REGS_VH

// ----------------------------------------
// Register indexes
// ----------------------------------------
`define IDX_DATA 3'h0
`define IDX_IER 3'h1
`define IDX_FIFO 3'h2
`define IDX_LCR 3'h3
`define IDX_MCR 3'h4
`define IDX_LSR 3'h5
`define IDX_MSR 3'h6
`define IDX_SPR 3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IER_RXD 0
`define IER_THRE 1
`define IER_LINE 2
`define IER_MODEM 3
`define IER_SLEEP 4
`define FCR_EN 0
`define FCR_RXRST 1
`define FCR_TXRST 2
`define FCR_DMA 3
`define LCR_DLAB 7
`define MCR_INTEN 3
`define MCR_LOOP 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IER_RST 6'h00
`define FCR_RST 8'h00
`define LCR_RST 8'h00
`define MCR_RST 5'h00
`define SPR_RST 8'hFF
`define DIV_RST 16'h0001
`define ISR_NONE 4'h1

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define FIFO_DEPTH 7'h40
`define TX_TRIG 7'h10
`define TRIG_0 7'h01
`define TRIG_1 7'h10
`define TRIG_2 7'h20
`define TRIG_3 7'h38
`define BIT_TICKS 16
`define CHAR_BITS 4'hA
`define TIMEOUT_CHARS 4
// Four characters of ten bits, sixteen ticks a bit
`define TIMEOUT_TICKS 10'h280

`endif

/* rtl/uart_aux.v */
// Purpose: UART core with time-out, baud generator, DMA pins, sleep, loop-back
// Assumes: 100 MHz clk is the baud reference; 8 data bits, 1 stop, no parity
// Notes: classic Wishbone slave, one word per register, data in bits 7:0
`include "uart_aux_regs.vh"

module uart_aux (
  // System
  input wire clk,
  input wire sys_rst,
  // Wishbone slave
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_stb_i,
  input wire wb_cyc_i,
  output reg wb_ack_o,
  // Serial and modem pins, modem pins active low
  input wire rx_pin,
  output reg tx_pin,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire dcd_n,
  output reg rts_n,
  output reg dtr_n,
  output reg general_output_a_n,
  output reg general_output_b_n,
  // Status pins
  output reg rx_ready_pin,
  output reg tx_ready_pin,
  output reg rate_x16_out,
  output reg irq,
  output reg sleep_state
);

  // ----------------------------------------
  // State machine codes
  // ----------------------------------------
  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA = 2'b10;
  localparam RX_STOP = 2'b11;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [5:0] interrupt_enable_reg;
  reg [7:0] fifo_control_reg;
  reg [7:0] lcr;
  reg [4:0] modem_control_reg;
  reg [7:0] spr;
  reg [7:0] dll;
  reg [7:0] divisor_high_byte;
  reg [4:0] sync1;
  reg [4:0] sync2;
  reg [4:0] pins_prev;
  reg [3:0] modem_prev;
  reg [3:0] delta;
  reg overrun;
  reg [7:0] rx_mem [0:63];
  reg [7:0] tx_mem [0:63];
  reg [5:0] rx_wp;
  reg [5:0] rx_rp;
  reg [6:0] rx_count;
  reg [5:0] tx_wp;
  reg [5:0] tx_rp;
  reg [6:0] tx_count;
  reg [15:0] baud_cnt;
  reg tick;
  reg [1:0] rx_st;
  reg [3:0] rx_tk;
  reg [2:0] rx_bit;
  reg [7:0] rx_sh;
  reg rx_push;
  reg stop_mid;
  reg tx_busy;
  reg [9:0] tx_sh;
  reg [3:0] tx_tk;
  reg [3:0] tx_n;
  reg tx_line;
  reg [9:0] to_cnt;
  reg [3:0] isr;
  reg [7:0] rd_val;

  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire mapped = (wb_adr_i[31:5] == 27'h0);
  wire [2:0] idx = wb_adr_i[4:2];
  wire dlab = lcr[`LCR_DLAB];
  wire wr = acc & wb_we_i & wb_sel_i[0] & mapped;
  wire rd = acc & ~wb_we_i & mapped;
  wire [7:0] wd = wb_dat_i[7:0];
  wire loop = modem_control_reg[`MCR_LOOP];
  wire fen = fifo_control_reg[`FCR_EN];

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function [6:0] trig_level;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: trig_level = `TRIG_0;
        2'b01: trig_level = `TRIG_1;
        2'b10: trig_level = `TRIG_2;
        default: trig_level = `TRIG_3;
      endcase
    end
  endfunction

  // FIFO depth collapses to one byte with FIFOs disabled
  wire [6:0] cap = fen ? `FIFO_DEPTH : 7'h01;
  wire [6:0] rx_trig = fen ? trig_level(fifo_control_reg[7:6]) : 7'h01;
  wire rx_full = (rx_count >= cap);
  wire tx_full = (tx_count >= cap);
  wire rx_empty = (rx_count == 7'h00);
  wire tx_empty = (tx_count == 7'h00);

  // ----------------------------------------
  // Loop-back routing and modem status
  // ----------------------------------------
  wire rx_line = loop ? tx_line : sync2[4];
  wire st_cts = loop ? modem_control_reg[0] : ~sync2[3];
  wire st_dsr = loop ? modem_control_reg[1] : ~sync2[2];
  wire st_ri = loop ? modem_control_reg[2] : ~sync2[1];
  wire st_dcd = loop ? modem_control_reg[3] : ~sync2[0];
  wire [3:0] modem_now = {st_dcd, st_ri, st_dsr, st_cts};

  // ----------------------------------------
  // Interrupt sources
  // ----------------------------------------
  wire timeout = ~rx_empty & (to_cnt == `TIMEOUT_TICKS);
  wire rx_lvl = (rx_count >= rx_trig) & ~rx_empty;
  wire int_line = interrupt_enable_reg[`IER_LINE] & overrun;
  wire int_rxd = interrupt_enable_reg[`IER_RXD] & rx_lvl;
  wire int_tmo = interrupt_enable_reg[`IER_RXD] & timeout;
  wire int_thre = interrupt_enable_reg[`IER_THRE] & tx_empty;
  wire int_msi = interrupt_enable_reg[`IER_MODEM] & (|delta);
  wire pending = int_line | int_rxd | int_tmo | int_thre | int_msi;

  always @* begin
    if (int_line)
      isr = 4'h6;
    else if (int_rxd)
      isr = 4'h4;
    else if (int_tmo)
      isr = 4'hC;
    else if (int_thre)
      isr = 4'h2;
    else if (int_msi)
      isr = 4'h0;
    else
      isr = `ISR_NONE;
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  always @* begin
    case (idx)
      `IDX_DATA: rd_val = dlab ? dll : rx_mem[rx_rp];
      `IDX_IER: rd_val = dlab ? divisor_high_byte : {2'b00, interrupt_enable_reg};
      `IDX_FIFO: rd_val = {fen, fen, fen & fifo_control_reg[5], 1'b0, isr};
      `IDX_LCR: rd_val = lcr;
      `IDX_MCR: rd_val = {3'b000, modem_control_reg};
      `IDX_LSR: rd_val = {1'b0, tx_empty & ~tx_busy, tx_empty, 3'b000, overrun, ~rx_empty};
      `IDX_MSR: rd_val = {modem_now, delta};
      default: rd_val = spr;
    endcase
  end

  // ----------------------------------------
  // Bus slave and registers
  // ----------------------------------------
  wire rhr_read = rd & (idx == `IDX_DATA) & ~dlab;
  wire thr_write = wr & (idx == `IDX_DATA) & ~dlab;
  wire fcr_write = wr & (idx == `IDX_FIFO);
  wire rx_clr = fcr_write & (wd[`FCR_RXRST] | (wd[`FCR_EN] != fen));
  wire tx_clr = fcr_write & (wd[`FCR_TXRST] | (wd[`FCR_EN] != fen));

  always @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      interrupt_enable_reg <= `IER_RST;
      fifo_control_reg <= `FCR_RST;
      lcr <= `LCR_RST;
      modem_control_reg <= `MCR_RST;
      spr <= `SPR_RST;
      {divisor_high_byte, dll} <= `DIV_RST;
    end else begin
      wb_ack_o <= acc;
      if (acc)
        wb_dat_o <= mapped & ~wb_we_i ? {24'h0, rd_val} : 32'h0;
      if (wr) begin
        case (idx)
          `IDX_DATA: if (dlab) dll <= wd;
          `IDX_IER: begin
            if (dlab)
              divisor_high_byte <= wd;
            else
              interrupt_enable_reg <= wd[5:0];
          end
          `IDX_FIFO: fifo_control_reg <= {wd[7:3], 2'b00, wd[0]};
          `IDX_LCR: lcr <= wd;
          `IDX_MCR: modem_control_reg <= wd[4:0];
          `IDX_SPR: spr <= wd;
          default: spr <= spr;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers and modem deltas
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= 5'h1F;
      sync2 <= 5'h1F;
      pins_prev <= 5'h1F;
      modem_prev <= 4'h0;
      delta <= 4'h0;
      overrun <= 1'b0;
    end else begin
      sync1 <= {rx_pin, cts_n, dsr_n, ri_n, dcd_n};
      sync2 <= sync1;
      pins_prev <= sync2;
      modem_prev <= modem_now;
      // Set wins over a same-cycle clear by read
      if (rd & (idx == `IDX_MSR))
        delta <= modem_now ^ modem_prev;
      else
        delta <= delta | (modem_now ^ modem_prev);
      if (rx_push & rx_full)
        overrun <= 1'b1;
      else if (rd & (idx == `IDX_LSR))
        overrun <= 1'b0;
    end
  end

  // ----------------------------------------
  // Baud generator
  // ----------------------------------------
  wire [15:0] div = ({divisor_high_byte, dll} == 16'h0) ? 16'h0001 : {divisor_high_byte, dll};
  wire [16:0] div_up = {1'b0, div} + 17'h00001;
  wire [15:0] half = div_up[16:1];

  always @(posedge clk) begin
    if (sys_rst) begin
      baud_cnt <= 16'h0;
      tick <= 1'b0;
      rate_x16_out <= 1'b0;
    end else if (sleep_state) begin
      baud_cnt <= 16'h0;
      tick <= 1'b0;
    end else begin
      // One tick per divisor count, shared by both directions
      tick <= (baud_cnt >= div - 16'h0001);
      if (baud_cnt >= div - 16'h0001)
        baud_cnt <= 16'h0;
      else
        baud_cnt <= baud_cnt + 16'h0001;
      rate_x16_out <= (baud_cnt < half);
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      rx_st <= RX_IDLE;
      rx_tk <= 4'h0;
      rx_bit <= 3'h0;
      rx_sh <= 8'h0;
      rx_push <= 1'b0;
      stop_mid <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      stop_mid <= 1'b0;
      if (tick) begin
        rx_tk <= rx_tk + 4'h1;
        case (rx_st)
          RX_IDLE: begin
            rx_tk <= 4'h0;
            if (!rx_line)
              rx_st <= RX_START;
          end
          RX_START: begin
            if (rx_tk == 4'h7) begin
              rx_tk <= 4'h0;
              rx_bit <= 3'h0;
              rx_st <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_tk == 4'hF) begin
              rx_sh <= {rx_line, rx_sh[7:1]};
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == 3'h7)
                rx_st <= RX_STOP;
            end
          end
          default: begin
            if (rx_tk == 4'hF) begin
              stop_mid <= 1'b1;
              rx_push <= 1'b1;
              rx_st <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Receive FIFO and time-out
  // ----------------------------------------
  wire rx_pop = rhr_read & ~rx_empty;
  wire rx_in = rx_push & ~rx_full;

  always @(posedge clk) begin
    if (rx_in)
      rx_mem[rx_wp] <= rx_sh;
  end

  always @(posedge clk) begin
    if (sys_rst | rx_clr) begin
      rx_wp <= 6'h0;
      rx_rp <= 6'h0;
      rx_count <= 7'h0;
    end else begin
      if (rx_in)
        rx_wp <= rx_wp + 6'h1;
      if (rx_pop)
        rx_rp <= rx_rp + 6'h1;
      if (rx_in & ~rx_pop)
        rx_count <= rx_count + 7'h01;
      else if (rx_pop & ~rx_in)
        rx_count <= rx_count - 7'h01;
    end
  end

  always @(posedge clk) begin
    if (sys_rst | stop_mid | rhr_read | rx_empty)
      to_cnt <= 10'h0;
    else if (tick & (to_cnt != `TIMEOUT_TICKS))
      to_cnt <= to_cnt + 10'h1;
  end

  // ----------------------------------------
  // Transmit FIFO and transmitter
  // ----------------------------------------
  wire tx_in = thr_write & ~tx_full;
  wire tx_load = ~tx_busy & ~tx_empty & tick;

  always @(posedge clk) begin
    if (tx_in)
      tx_mem[tx_wp] <= wd;
  end

  always @(posedge clk) begin
    if (sys_rst | tx_clr) begin
      tx_wp <= 6'h0;
      tx_rp <= 6'h0;
      tx_count <= 7'h0;
    end else begin
      if (tx_in)
        tx_wp <= tx_wp + 6'h1;
      if (tx_load)
        tx_rp <= tx_rp + 6'h1;
      if (tx_in & ~tx_load)
        tx_count <= tx_count + 7'h01;
      else if (tx_load & ~tx_in)
        tx_count <= tx_count - 7'h01;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      tx_busy <= 1'b0;
      tx_sh <= 10'h3FF;
      tx_tk <= 4'h0;
      tx_n <= 4'h0;
      tx_line <= 1'b1;
    end else if (tx_load) begin
      tx_busy <= 1'b1;
      tx_sh <= {1'b1, tx_mem[tx_rp], 1'b0};
      tx_tk <= 4'h0;
      tx_n <= 4'h0;
      tx_line <= 1'b0;
    end else if (tx_busy & tick) begin
      tx_tk <= tx_tk + 4'h1;
      if (tx_tk == 4'hF) begin
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_line <= tx_sh[1];
        tx_n <= tx_n + 4'h1;
        if (tx_n == `CHAR_BITS - 4'h1) begin
          tx_busy <= 1'b0;
          tx_line <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Sleep control
  // ----------------------------------------
  wire wake = ~rx_line | (sync2 != pins_prev) | thr_write;
  wire idle = rx_empty & tx_empty & ~tx_busy & (rx_st == RX_IDLE);

  always @(posedge clk) begin
    if (sys_rst)
      sleep_state <= 1'b0;
    else
      sleep_state <= interrupt_enable_reg[`IER_SLEEP] & idle & ~pending & ~wake;
  end

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      tx_pin <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      general_output_a_n <= 1'b1;
      general_output_b_n <= 1'b1;
      rx_ready_pin <= 1'b1;
      tx_ready_pin <= 1'b0;
      irq <= 1'b0;
    end else begin
      tx_pin <= loop | tx_line;
      dtr_n <= loop | ~modem_control_reg[0];
      rts_n <= loop | ~modem_control_reg[1];
      general_output_a_n <= loop | ~modem_control_reg[2];
      general_output_b_n <= loop | ~modem_control_reg[3];
      irq <= pending & (loop | modem_control_reg[`MCR_INTEN]);
      if (!fifo_control_reg[`FCR_DMA])
        rx_ready_pin <= rx_empty;
      else if (rx_empty)
        rx_ready_pin <= 1'b1;
      else if (rx_lvl | timeout)
        rx_ready_pin <= 1'b0;
      if (!fifo_control_reg[`FCR_DMA])
        tx_ready_pin <= ~tx_empty;
      else if (tx_full)
        tx_ready_pin <= 1'b1;
      else if (tx_count < `TX_TRIG)
        tx_ready_pin <= 1'b0;
    end
  end

endmodule

/* dv/uart_aux_monitor.sv */
// Purpose: concurrent checks on the UART auxiliary block ports
// Assumes: single clock domain, synchronous active-high reset
// Notes: shadows divisor, line, enable and modem control writes from the bus
module uart_aux_monitor (
  // System
  input wire clk,
  input wire sys_rst,
  // Bus
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_stb_i,
  input wire wb_cyc_i,
  input wire wb_ack_o,
  // Pins
  input wire tx_pin,
  input wire rts_n,
  input wire dtr_n,
  input wire general_output_a_n,
  input wire general_output_b_n,
  input wire rate_x16_out,
  input wire irq,
  input wire sleep_state
);
  logic lcr7;
  logic [4:0] modem_control_reg;
  logic [5:0] interrupt_enable_reg;
  logic [15:0] div;
  logic [15:0] gap;
  logic seen;
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wtake = take && wb_we_i && wb_sel_i[0] && (wb_adr_i[31:5] == 27'h0000000);
  wire [2:0] idx = wb_adr_i[4:2];

  // ----------------------------------------
  // Register shadows
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      lcr7 <= 1'b0;
      modem_control_reg <= 5'h00;
      interrupt_enable_reg <= 6'h00;
      div <= 16'h0001;
    end else if (wtake) begin
      if (idx == 3'h3) lcr7 <= wb_dat_i[7];
      if (idx == 3'h4) modem_control_reg <= wb_dat_i[4:0];
      if (idx == 3'h1 && !lcr7) interrupt_enable_reg <= wb_dat_i[5:0];
      if (idx == 3'h0 && lcr7) div[7:0] <= wb_dat_i[7:0];
      if (idx == 3'h1 && lcr7) div[15:8] <= wb_dat_i[7:0];
    end
  end

  // Gap between rate pulses; only trusted after a full period on one divisor
  always @(posedge clk) begin
    gap <= $rose(rate_x16_out) ? 16'h0001 : gap + 16'h0001;
    if (sys_rst || sleep_state || (wtake && idx[2:1] == 2'b00 && lcr7)) seen <= 1'b0;
    else if ($rose(rate_x16_out)) seen <= 1'b1;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_ack_answer: assert property (take |=> wb_ack_o)
    else $error("bus ack missing one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_loop_quiet: assert property (
    modem_control_reg[4] && $past(modem_control_reg[4]) |-> tx_pin && rts_n && dtr_n && general_output_a_n
    && general_output_b_n) else $error("outputs active during loop-back");
  chk_modem_follow: assert property (
    modem_control_reg == $past(modem_control_reg, 2) && !modem_control_reg[4] |-> rts_n == !modem_control_reg[1] && dtr_n == !modem_control_reg[0]
    && general_output_a_n == !modem_control_reg[2] && general_output_b_n == !modem_control_reg[3])
    else $error("modem outputs do not follow modem control");
  chk_rate_period: assert property ($rose(rate_x16_out) && seen |-> gap == div)
    else $error("rate output period differs from divisor");
  chk_sleep_pending: assert property (irq |-> !sleep_state)
    else $error("asleep with interrupt pending");
  chk_sleep_enable: assert property (!interrupt_enable_reg[4] && !$past(interrupt_enable_reg[4]) |-> !sleep_state)
    else $error("asleep with sleep enable clear");

  cover property ($rose(sleep_state));
  cover property (modem_control_reg[4] && $rose(wb_ack_o));
  cover property ($rose(irq));
endmodule

bind uart_aux uart_aux_monitor u_uart_aux_monitor (
  .clk(clk),
  .sys_rst(sys_rst),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i),
  .wb_stb_i(wb_stb_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_ack_o(wb_ack_o),
  .tx_pin(tx_pin),
  .rts_n(rts_n),
  .dtr_n(dtr_n),
  .general_output_a_n(general_output_a_n),
  .general_output_b_n(general_output_b_n),
  .rate_x16_out(rate_x16_out),
  .irq(irq),
  .sleep_state(sleep_state)
);

/* dv/uart_line_partner.sv */
// Purpose: far-side serial line and modem inputs
// Assumes: 8N1 framing, bit period given in clk cycles
// Notes: modem inputs are active low and rest inactive
module uart_line_partner #(
  parameter int BIT_CYCLES = 64
) (
  // System
  input wire clk,
  // Serial
  input wire tx_pin,
  output logic rx_pin,
  // Modem inputs
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic dcd_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_pin = 1'b1;
    cts_n = 1'b1;
    dsr_n = 1'b1;
    ri_n = 1'b1;
    dcd_n = 1'b1;
  end
  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin <= f[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
  endtask
  task recv(output logic [7:0] b);
    int n;
    n = 0;
    while (tx_pin !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      b[i] = tx_pin;
    end
  endtask
  task flip_cts;
    cts_n <= ~cts_n;
  endtask
endmodule

/* dv/uart_timeout_baud_dma_sleep_loop_test.sv */
// Purpose: self-checking bench for the UART auxiliary block
// Assumes: divisor 4, so one bit is 64 clk cycles
// Notes: classic Wishbone master tasks, serial far side in a partner model
module uart_timeout_baud_dma_sleep_loop_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 64;
  logic clk, sys_rst, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic rx_pin, tx_pin, cts_n, dsr_n, ri_n, dcd_n, rts_n, dtr_n;
  logic general_output_a_n, general_output_b_n;
  logic rx_ready_pin, tx_ready_pin, rate_x16_out, irq, sleep_state;
  logic [7:0] b;
  int num_errors = 0;
  int check_count = 0;

  uart_aux u_uart_aux (.clk(clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n),
    .rts_n(rts_n), .dtr_n(dtr_n), .general_output_a_n(general_output_a_n),
    .general_output_b_n(general_output_b_n), .rx_ready_pin(rx_ready_pin),
    .tx_ready_pin(tx_ready_pin), .rate_x16_out(rate_x16_out), .irq(irq),
    .sleep_state(sleep_state));
  uart_line_partner #(.BIT_CYCLES(BIT)) u_uart_line_partner (.clk(clk), .tx_pin(tx_pin),
    .rx_pin(rx_pin), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task xfer(input logic [31:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {24'h000000, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    chk("bus ack", 1'b1, wb_ack_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task wr(input logic [2:0] i, input logic [7:0] d);
    logic [31:0] q;
    xfer({27'h0000000, i, 2'b00}, 1'b1, d, q);
  endtask
  task rd(input logic [2:0] i, input logic [7:0] e, input logic [7:0] m, input string nm);
    logic [31:0] q;
    xfer({27'h0000000, i, 2'b00}, 1'b0, 8'h00, q);
    chk(nm, {24'h000000, e & m}, q & {24'hFFFFFF, m});
  endtask
  function logic pick(input int w);
    return (w == 0) ? rx_ready_pin : (w == 1) ? sleep_state : irq;
  endfunction
  task waitv(input int w, input logic v, input int lim, input string nm);
    int n;
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(nm, v, pick(w));
  endtask
  task results;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    results;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    sys_rst = 1'b1;
    wb_adr_i = 32'h00000000;
    wb_dat_i = 32'h00000000;
    wb_we_i = 1'b0;
    wb_sel_i = 4'hF;
    wb_stb_i = 1'b0;
    wb_cyc_i = 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(3'h7, 8'hFF, 8'hFF, "scratch reset");
    rd(3'h5, 8'h60, 8'hFF, "line status reset");
    rd(3'h2, 8'h01, 8'hFF, "isr fifo off");
    chk("rx_ready_pin reset", 1'b1, rx_ready_pin);
    chk("tx_ready_pin reset", 1'b0, tx_ready_pin);
    xfer(32'h00000020, 1'b0, 8'h00, q);
    chk("unmapped read", 32'h00000000, q);
    // Divisor 4 gives 64 cycles a bit
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h04);
    wr(3'h1, 8'h00);
    rd(3'h0, 8'h04, 8'hFF, "divisor low");
    rd(3'h1, 8'h00, 8'hFF, "divisor high");
    wr(3'h3, 8'h00);
    wr(3'h2, 8'h01);
    u_uart_line_partner.send(8'hA5);
    waitv(0, 1'b0, 100, "rx_ready_pin filled");
    rd(3'h5, 8'h61, 8'hFF, "data ready set");
    rd(3'h0, 8'hA5, 8'hFF, "rx byte");
    waitv(0, 1'b1, 5, "rx_ready_pin empty");
    rd(3'h5, 8'h60, 8'hFF, "data ready clear");
    // Time-out in DMA mode with trigger 56
    wr(3'h1, 8'h01);
    wr(3'h4, 8'h08);
    wr(3'h2, 8'hC9);
    u_uart_line_partner.send(8'h11);
    u_uart_line_partner.send(8'h22);
    repeat (2000) @(posedge clk);
    chk("irq early", 1'b0, irq);
    chk("rx_ready_pin below trigger", 1'b1, rx_ready_pin);
    waitv(2, 1'b1, 800, "irq timeout");
    rd(3'h2, 8'hCC, 8'hFF, "isr timeout");
    chk("rx_ready_pin timeout", 1'b0, rx_ready_pin);
    rd(3'h0, 8'h11, 8'hFF, "first byte");
    repeat (2000) @(posedge clk);
    chk("irq restarted", 1'b0, irq);
    chk("rx_ready_pin not empty", 1'b0, rx_ready_pin);
    waitv(2, 1'b1, 800, "irq second timeout");
    rd(3'h0, 8'h22, 8'hFF, "second byte");
    waitv(0, 1'b1, 5, "rx_ready_pin drained");
    repeat (3000) @(posedge clk);
    chk("irq fifo empty", 1'b0, irq);
    rd(3'h2, 8'hC1, 8'hFF, "isr fifo empty");
    // Loop-back
    wr(3'h2, 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h1F);
    rd(3'h6, 8'hF0, 8'hF0, "modem status loop");
    wr(3'h0, 8'h3C);
    wr(3'h0, 8'hC3);
    repeat (3) @(posedge clk);
    chk("tx_ready_pin holding", 1'b1, tx_ready_pin);
    waitv(0, 1'b0, 1500, "rx_ready_pin loop");
    rd(3'h0, 8'h3C, 8'hFF, "loop byte one");
    repeat (700) @(posedge clk);
    rd(3'h0, 8'hC3, 8'hFF, "loop byte two");
    chk("tx_ready_pin drained", 1'b0, tx_ready_pin);
    wr(3'h4, 8'h00);
    rd(3'h6, 8'h00, 8'hF0, "modem status pins");
    wr(3'h0, 8'h5A);
    u_uart_line_partner.recv(b);
    chk("tx line byte", 8'h5A, b);
    repeat (700) @(posedge clk);
    // DMA transmit-ready: high once full, low below trigger
    wr(3'h2, 8'h09);
    for (int i = 0; i < 65; i++) wr(3'h0, i[7:0]);
    repeat (2) @(posedge clk);
    chk("tx_ready_pin full", 1'b1, tx_ready_pin);
    wr(3'h2, 8'h0D);
    repeat (2) @(posedge clk);
    chk("tx_ready_pin below trigger", 1'b0, tx_ready_pin);
    repeat (700) @(posedge clk);
    // Sleep entry, wake and return
    wr(3'h1, 8'h10);
    waitv(1, 1'b1, 50, "asleep");
    u_uart_line_partner.flip_cts();
    waitv(1, 1'b0, 10, "woken by pin");
    waitv(1, 1'b1, 50, "asleep again");
    u_uart_line_partner.send(8'h66);
    chk("awake with unread byte", 1'b0, sleep_state);
    rd(3'h0, 8'h66, 8'hFF, "sleep byte");
    waitv(1, 1'b1, 50, "asleep after read");
    wr(3'h1, 8'h12);
    repeat (20) @(posedge clk);
    chk("awake with pending", 1'b0, sleep_state);
    rd(3'h2, 8'hC2, 8'hFF, "isr tx empty");
    wr(3'h1, 8'h00);
    repeat (5) @(posedge clk);
    chk("awake when disabled", 1'b0, sleep_state);
    results;
  end
endmodule
